/* hw/ail_pkg.sv */
// Constants and types for the converter interrupt and limit status block.
`default_nettype none
package ail_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int NSRC = 8;
  localparam int SMP_W = 9;
  localparam logic [3:0] OFS_INT_ENABLE = 4'h9;
  localparam logic [3:0] OFS_INT_FLAGS = 4'ha;
  localparam logic [3:0] OFS_LIMIT_HIT = 4'hd;
  localparam int SRC_WDOG = 0;
  localparam int SRC_IMATCH = 1;
  localparam int SRC_FIFO = 2;
  localparam int SRC_AZERO = 3;
  localparam int SRC_FULLCAL = 4;
  localparam int SRC_PAUSE = 5;
  localparam int SRC_STBY = 7;
  localparam logic [7:0] SRC_USED_MASK = 8'hbf;
  localparam int TRIG_LSB = 8;
  localparam int TRIG_W = 3;
  localparam int THR_LSB = 11;
  localparam int THR_W = 5;
  localparam int LIM2_LSB = 8;
  localparam int FCNT_W = 6;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int STBY_SETTLE_MS = 10;
  localparam int STBY_SETTLE_CYC = STBY_SETTLE_MS * CLK_FREQ_KHZ;
  localparam int SETTLE_W = 22;
  localparam int PIN_W = 23;
  localparam int PIN_DIN_LSB = 0;
  localparam int PIN_ADDR_LSB = 16;
  localparam int PIN_WR = 20;
  localparam int PIN_RD = 21;
  localparam int PIN_CS = 22;
  localparam logic [PIN_W-1:0] PIN_IDLE = 23'h70_0000;
  typedef enum logic [2:0] {
    WD_IDLE = 3'h1,
    WD_LIM1 = 3'h2,
    WD_LIM2 = 3'h4
  } ail_wd_state_t;
endpackage
`default_nettype wire

/* hw/ail_int_ctrl.sv */
// Interrupt flags, enables and watchdog limit status of the converter.
`default_nettype none
// Contract
// R1: seven equal sources, unmasked flag drives interrupt
// R2: host reads flags after every enable write
// R3: watchdog compares limit one then limit two
// R4: pointer equals trigger field flags source one
// R5: FIFO count equals nonzero threshold flags source two
// R6: short auto-zero completion flags source three
// R7: full calibration completion flags source four
// R8: fetched pause instruction flags source five
// R9: standby exit plus settling delay flags seven
// R10: flags set regardless of enable bits
// R11: enable and status bit six ignored
// R12: trigger zero skips first fetch of zero
// R13: interrupts never halt the sequencer
// R14: reading flags or device reset clears them
// R15: status shows pointer and FIFO count running
// R16: limit bit n or n+8 per limit hit
// R17: reading limit status or reset clears it
// R18: reset bit clears flags, restarts sequencer state
// R19: interrupt low while enabled flag stays set
module ail_int_ctrl #(
  parameter int STBY_SETTLE_CYCLES = ail_pkg::STBY_SETTLE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] db_in,
  output logic      [15:0] db_out,
  output logic             db_oe,
  output logic             int_n,
  output logic             seq_clear,
  input  wire logic        fetch_valid,
  input  wire logic [2:0]  fetch_ptr,
  input  wire logic        fetch_pause,
  input  wire logic        seq_running,
  input  wire logic [2:0]  instruction_pointer,
  input  wire logic [5:0]  fifo_count,
  input  wire logic        azero_done,
  input  wire logic        fullcal_done,
  input  wire logic        standby_bit,
  input  wire logic        cfg_reset_pulse,
  input  wire logic        wd_start,
  input  wire logic [2:0]  wd_instr,
  input  wire logic [8:0]  wd_sample,
  input  wire logic [8:0]  wd_lim1,
  input  wire logic        wd_lim1_above,
  input  wire logic [8:0]  wd_lim2,
  input  wire logic        wd_lim2_above
);
  function automatic logic wd_hit(input logic [8:0] s, input logic [8:0] l, input logic above);
    wd_hit = above ? ($signed(s) > $signed(l)) : ($signed(s) < $signed(l));
  endfunction
  function automatic logic is_mapped(input logic [3:0] a);
    is_mapped = (a == ail_pkg::OFS_INT_ENABLE) || (a == ail_pkg::OFS_INT_FLAGS) ||
                (a == ail_pkg::OFS_LIMIT_HIT);
  endfunction
  logic [22:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg, pin_f_next;
  logic        rd_act_reg, wr_act_reg;
  logic [3:0]  rd_addr_reg, rd_addr_next;
  logic [15:0] en_reg, en_next;
  logic [7:0]  flags_reg, flags_next, flag_snap_reg, flag_snap_next;
  logic [15:0] limit_reg, limit_next, limit_snap_reg, limit_snap_next;
  logic [15:0] dout_reg, dout_next;
  logic        oe_reg, oe_next, int_n_reg, int_n_next, seq_clr_reg, seq_clr_next;
  logic        first_fetch_reg, first_fetch_next, fifo_eq_reg, stby_d_reg, settle_act_reg, settle_act_next;
  logic [21:0] settle_cnt_reg, settle_cnt_next;
  ail_pkg::ail_wd_state_t wd_state_reg, wd_state_next;
  logic [2:0]  wd_instr_reg, wd_instr_next;
  logic [8:0]  wd_sample_reg, wd_sample_next, wd_l1_reg, wd_l1_next, wd_l2_reg, wd_l2_next;
  logic        wd_a1_reg, wd_a1_next, wd_a2_reg, wd_a2_next;
  logic        rd_act, wr_act, rd_go, rd_end, wr_end;
  logic [3:0]  f_addr;
  logic [15:0] f_din;
  logic [2:0]  trig;
  logic [4:0]  thr;
  logic        fifo_eq, stby_fall, dev_clear, hit1, hit2;
  logic [7:0]  set_vec, enabled;
  logic [15:0] lim_set, status_word;
  // A pin change counts once the second and third stages agree.
  assign pin_f_next = (pin_s3_reg & ~(pin_s2_reg ^ pin_s3_reg)) | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
  assign rd_act = ~pin_f_reg[ail_pkg::PIN_CS] & ~pin_f_reg[ail_pkg::PIN_RD];
  assign wr_act = ~pin_f_reg[ail_pkg::PIN_CS] & ~pin_f_reg[ail_pkg::PIN_WR];
  assign rd_go = rd_act & ~rd_act_reg;
  assign rd_end = ~rd_act & rd_act_reg;
  assign wr_end = ~wr_act & wr_act_reg;
  assign f_addr = pin_f_reg[ail_pkg::PIN_ADDR_LSB +: ail_pkg::ADDR_W];
  assign f_din = pin_f_reg[ail_pkg::PIN_DIN_LSB +: ail_pkg::DATA_W];
  assign trig = en_reg[ail_pkg::TRIG_LSB +: ail_pkg::TRIG_W];
  assign thr = en_reg[ail_pkg::THR_LSB +: ail_pkg::THR_W];
  assign fifo_eq = ({1'b0, thr} == fifo_count);
  assign stby_fall = stby_d_reg & ~standby_bit;
  assign dev_clear = cfg_reset_pulse | stby_fall;
  assign hit1 = (wd_state_reg == ail_pkg::WD_LIM1) && wd_hit(wd_sample_reg, wd_l1_reg, wd_a1_reg);
  assign hit2 = (wd_state_reg == ail_pkg::WD_LIM2) && wd_hit(wd_sample_reg, wd_l2_reg, wd_a2_reg);
  assign enabled = flags_reg & en_reg[7:0] & ail_pkg::SRC_USED_MASK;
  // Event detection; every source sets its flag whatever its enable bit holds. R10
  always_comb begin
    set_vec = 8'h00;
    set_vec[ail_pkg::SRC_WDOG] = hit1 | hit2; // R3
    set_vec[ail_pkg::SRC_IMATCH] = fetch_valid && (fetch_ptr == trig) &&
                                   !(first_fetch_reg && (fetch_ptr == 3'h0)); // R4 R12
    set_vec[ail_pkg::SRC_FIFO] = fifo_eq && !fifo_eq_reg && (thr != 5'h00); // R5
    set_vec[ail_pkg::SRC_AZERO] = azero_done; // R6
    set_vec[ail_pkg::SRC_FULLCAL] = fullcal_done; // R7
    set_vec[ail_pkg::SRC_PAUSE] = fetch_valid && fetch_pause; // R8
    set_vec[ail_pkg::SRC_STBY] = settle_act_reg && !standby_bit && (settle_cnt_reg == 22'h00_0001); // R9
    set_vec = set_vec & ail_pkg::SRC_USED_MASK; // R11
    lim_set = 16'h0000;
    if (hit1) begin
      lim_set[wd_instr_reg] = 1'b1; // R16
    end
    if (hit2) begin
      lim_set[ail_pkg::LIM2_LSB + int'(wd_instr_reg)] = 1'b1; // R16
    end
  end
  // Pointer and FIFO count read back only while the sequencer runs.
  always_comb begin
    status_word = {8'h00, flags_reg & ail_pkg::SRC_USED_MASK};
    if (seq_running) begin
      status_word[ail_pkg::TRIG_LSB +: ail_pkg::TRIG_W] = instruction_pointer; // R15
      status_word[ail_pkg::THR_LSB +: ail_pkg::THR_W] = fifo_count[4:0]; // R15
    end
  end
  // Host access, flag bookkeeping and interrupt output.
  always_comb begin
    rd_addr_next = rd_go ? f_addr : rd_addr_reg;
    en_next = en_reg;
    if (wr_end && (f_addr == ail_pkg::OFS_INT_ENABLE)) begin
      en_next = f_din;
    end
    dout_next = dout_reg;
    flag_snap_next = flag_snap_reg;
    limit_snap_next = limit_snap_reg;
    if (rd_go) begin
      case (f_addr)
        ail_pkg::OFS_INT_ENABLE: dout_next = en_reg;
        ail_pkg::OFS_INT_FLAGS: dout_next = status_word;
        ail_pkg::OFS_LIMIT_HIT: dout_next = limit_reg;
        default: dout_next = 16'h0000;
      endcase
      flag_snap_next = (f_addr == ail_pkg::OFS_INT_FLAGS) ? flags_reg : 8'h00;
      limit_snap_next = (f_addr == ail_pkg::OFS_LIMIT_HIT) ? limit_reg : 16'h0000;
    end
    oe_next = rd_go ? is_mapped(f_addr) : (rd_act & oe_reg);
    // Only the bits the host actually saw are cleared, and a new set wins.
    flags_next = flags_reg;
    limit_next = limit_reg;
    if (rd_end && (rd_addr_reg == ail_pkg::OFS_INT_FLAGS)) begin
      flags_next = flags_reg & ~flag_snap_reg; // R14
    end
    if (rd_end && (rd_addr_reg == ail_pkg::OFS_LIMIT_HIT)) begin
      limit_next = limit_reg & ~limit_snap_reg; // R17
    end
    flags_next = flags_next | set_vec;
    limit_next = limit_next | lim_set;
    if (dev_clear) begin
      flags_next = ail_pkg::FLAGS_RESET; // R14 R18
      limit_next = ail_pkg::LIMIT_RESET; // R17 R18
    end
    int_n_next = ~(|enabled); // R1 R19
    // Interrupts are not fed back to the sequencer; only the reset bit or a standby exit stops it. R13
    seq_clr_next = dev_clear; // R18
    first_fetch_next = dev_clear ? 1'b1 : (fetch_valid ? 1'b0 : first_fetch_reg); // R12
  end
  // Standby settling timer.
  always_comb begin
    settle_cnt_next = settle_cnt_reg;
    settle_act_next = settle_act_reg;
    if (standby_bit) begin
      settle_act_next = 1'b0;
    end else if (stby_fall) begin
      settle_cnt_next = ail_pkg::SETTLE_W'(STBY_SETTLE_CYCLES); // R9
      settle_act_next = 1'b1;
    end else if (settle_act_reg) begin
      settle_cnt_next = settle_cnt_reg - 22'h00_0001;
      settle_act_next = (settle_cnt_reg != 22'h00_0001);
    end
  end
  // Watchdog comparison sequencing: limit one, then limit two.
  always_comb begin
    wd_state_next = wd_state_reg;
    wd_instr_next = wd_instr_reg;
    wd_sample_next = wd_sample_reg;
    wd_l1_next = wd_l1_reg;
    wd_l2_next = wd_l2_reg;
    wd_a1_next = wd_a1_reg;
    wd_a2_next = wd_a2_reg;
    case (wd_state_reg)
      ail_pkg::WD_IDLE: begin
        if (wd_start) begin
          wd_state_next = ail_pkg::WD_LIM1; // R3
          wd_instr_next = wd_instr;
          wd_sample_next = wd_sample;
          wd_l1_next = wd_lim1;
          wd_l2_next = wd_lim2;
          wd_a1_next = wd_lim1_above;
          wd_a2_next = wd_lim2_above;
        end
      end
      ail_pkg::WD_LIM1: wd_state_next = ail_pkg::WD_LIM2; // R3
      ail_pkg::WD_LIM2: wd_state_next = ail_pkg::WD_IDLE;
      default: wd_state_next = ail_pkg::WD_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_s1_reg <= ail_pkg::PIN_IDLE;
      pin_s2_reg <= ail_pkg::PIN_IDLE;
      pin_s3_reg <= ail_pkg::PIN_IDLE;
      pin_f_reg <= ail_pkg::PIN_IDLE;
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      rd_addr_reg <= 4'h0;
      en_reg <= ail_pkg::ENABLE_RESET;
      flags_reg <= ail_pkg::FLAGS_RESET;
      flag_snap_reg <= 8'h00;
      limit_reg <= ail_pkg::LIMIT_RESET;
      limit_snap_reg <= 16'h0000;
      dout_reg <= 16'h0000;
      oe_reg <= 1'b0;
      int_n_reg <= 1'b1;
      seq_clr_reg <= 1'b0;
      first_fetch_reg <= 1'b1;
      fifo_eq_reg <= 1'b0;
      stby_d_reg <= 1'b0;
      settle_cnt_reg <= 22'h00_0000;
      settle_act_reg <= 1'b0;
      wd_state_reg <= ail_pkg::WD_IDLE;
      wd_instr_reg <= 3'h0;
      wd_sample_reg <= 9'h000;
      wd_l1_reg <= 9'h000;
      wd_l2_reg <= 9'h000;
      wd_a1_reg <= 1'b0;
      wd_a2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {cs_n, rd_n, wr_n, addr, db_in};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_f_reg <= pin_f_next;
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
      rd_addr_reg <= rd_addr_next;
      en_reg <= en_next;
      flags_reg <= flags_next;
      flag_snap_reg <= flag_snap_next;
      limit_reg <= limit_next;
      limit_snap_reg <= limit_snap_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      int_n_reg <= int_n_next;
      seq_clr_reg <= seq_clr_next;
      first_fetch_reg <= first_fetch_next;
      fifo_eq_reg <= fifo_eq;
      stby_d_reg <= standby_bit;
      settle_cnt_reg <= settle_cnt_next;
      settle_act_reg <= settle_act_next;
      wd_state_reg <= wd_state_next;
      wd_instr_reg <= wd_instr_next;
      wd_sample_reg <= wd_sample_next;
      wd_l1_reg <= wd_l1_next;
      wd_l2_reg <= wd_l2_next;
      wd_a1_reg <= wd_a1_next;
      wd_a2_reg <= wd_a2_next;
    end
  end
  assign db_out = dout_reg;
  assign db_oe = oe_reg;
  assign int_n = int_n_reg;
  assign seq_clear = seq_clr_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_wd_run;
    (wd_state_reg == ail_pkg::WD_LIM1) ##1 (wd_state_reg == ail_pkg::WD_LIM2) ##1 (wd_state_reg == ail_pkg::WD_IDLE);
  endsequence
  property p_r3_order;
    (wd_state_reg == ail_pkg::WD_IDLE) && wd_start |=> s_wd_run;
  endproperty
  a_r3_order: assert property (p_r3_order) else $error("watchdog compare order wrong"); // R3
  property p_r1_int;
    (|enabled) |=> !int_n_reg;
  endproperty
  a_r1_int: assert property (p_r1_int) else $error("enabled flag did not pull interrupt low"); // R1
  property p_r19_release;
    !(|enabled) |=> int_n_reg;
  endproperty
  a_r19_release: assert property (p_r19_release) else $error("interrupt low without enabled flag"); // R19
  property p_r4_match;
    fetch_valid && (fetch_ptr == trig) && !first_fetch_reg && !dev_clear |=> flags_reg[ail_pkg::SRC_IMATCH];
  endproperty
  a_r4_match: assert property (p_r4_match) else $error("pointer match not flagged"); // R4
  property p_r12_first;
    fetch_valid && first_fetch_reg && (fetch_ptr == 3'h0) && (trig == 3'h0) && !flags_reg[ail_pkg::SRC_IMATCH]
      |=> !flags_reg[ail_pkg::SRC_IMATCH];
  endproperty
  a_r12_first: assert property (p_r12_first) else $error("first fetch of zero flagged"); // R12
  property p_r5_fifo;
    fifo_eq && !fifo_eq_reg && (thr != 5'h00) && !dev_clear |=> flags_reg[ail_pkg::SRC_FIFO];
  endproperty
  a_r5_fifo: assert property (p_r5_fifo) else $error("FIFO threshold not flagged"); // R5
  property p_r6_azero;
    azero_done && !en_reg[ail_pkg::SRC_AZERO] && !dev_clear |=> flags_reg[ail_pkg::SRC_AZERO];
  endproperty
  a_r6_azero: assert property (p_r6_azero) else $error("masked auto-zero not flagged"); // R6 R10
  property p_r8_pause;
    fetch_valid && fetch_pause && !dev_clear |=> flags_reg[ail_pkg::SRC_PAUSE] && !seq_clr_reg;
  endproperty
  a_r8_pause: assert property (p_r8_pause) else $error("pause not flagged"); // R8 R13
  property p_r9_load;
    stby_fall |=> settle_act_reg && (settle_cnt_reg == ail_pkg::SETTLE_W'(STBY_SETTLE_CYCLES));
  endproperty
  a_r9_load: assert property (p_r9_load) else $error("settle timer not loaded"); // R9
  property p_r11_six;
    !flags_reg[6];
  endproperty
  a_r11_six: assert property (p_r11_six) else $error("flag six set"); // R11
  property p_r14_clear;
    rd_end && (rd_addr_reg == ail_pkg::OFS_INT_FLAGS) && (set_vec == 8'h00) |=> ((flags_reg & $past(flag_snap_reg)) == 8'h00);
  endproperty
  a_r14_clear: assert property (p_r14_clear) else $error("flags not cleared by read"); // R14
  property p_r16_lim2;
    hit2 && !dev_clear |=> limit_reg[ail_pkg::LIM2_LSB + int'($past(wd_instr_reg))] && flags_reg[ail_pkg::SRC_WDOG];
  endproperty
  a_r16_lim2: assert property (p_r16_lim2) else $error("limit two hit not recorded"); // R16
  property p_r18_reset;
    cfg_reset_pulse |=> (flags_reg == 8'h00) && (limit_reg == 16'h0000) && seq_clr_reg && first_fetch_reg;
  endproperty
  a_r18_reset: assert property (p_r18_reset) else $error("reset bit did not clear state"); // R17 R18
endmodule
`default_nettype wire

/* bench/ail_host_model.sv */
// Host processor model that drives the converter's parallel register pins.
`default_nettype none
module ail_host_model (
  input  wire logic        sys_clk,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic      [3:0]  addr,
  output logic      [15:0] db_in,
  input  wire logic [15:0] db_out,
  input  wire logic        db_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 4'h0;
    db_in = 16'h0000;
  end
  // Data is kept past the filtered strobe rise, then turned to its inverse so stale data never looks valid.
  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    db_in <= d;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    db_in <= ~d;
  endtask
  task automatic bus_read(input logic [3:0] a, output logic [15:0] d, output logic oe);
    @(posedge sys_clk);
    addr <= a;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    d = db_out;
    oe = db_oe;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* bench/ail_int_ctrl_test.sv */
// Self-checking testbench for the converter interrupt and limit status block.
`default_nettype none
module ail_int_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SETTLE = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, rd_n, wr_n, db_oe, int_n, seq_clear;
  logic [3:0] addr;
  logic [15:0] db_in, db_out;
  logic fetch_valid = 1'b0, fetch_pause = 1'b0, seq_running = 1'b0;
  logic [2:0] fetch_ptr = 3'h0, instruction_pointer = 3'h0, wd_instr = 3'h0;
  logic [5:0] fifo_count = 6'h00;
  logic azero_done = 1'b0, fullcal_done = 1'b0, standby_bit = 1'b0, cfg_reset_pulse = 1'b0;
  logic wd_start = 1'b0, wd_lim1_above = 1'b0, wd_lim2_above = 1'b0;
  logic [8:0] wd_sample = 9'h000, wd_lim1 = 9'h000, wd_lim2 = 9'h000;
  int bad_count = 0;
  int compares = 0;
  always #2 sys_clk = ~sys_clk;
  ail_host_model host (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .db_in(db_in), .db_out(db_out), .db_oe(db_oe));
  ail_int_ctrl #(.STBY_SETTLE_CYCLES(SETTLE)) uut (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .int_n(int_n),
    .seq_clear(seq_clear), .fetch_valid(fetch_valid), .fetch_ptr(fetch_ptr), .fetch_pause(fetch_pause),
    .seq_running(seq_running), .instruction_pointer(instruction_pointer), .fifo_count(fifo_count),
    .azero_done(azero_done), .fullcal_done(fullcal_done), .standby_bit(standby_bit),
    .cfg_reset_pulse(cfg_reset_pulse), .wd_start(wd_start), .wd_instr(wd_instr), .wd_sample(wd_sample),
    .wd_lim1(wd_lim1), .wd_lim1_above(wd_lim1_above), .wd_lim2(wd_lim2), .wd_lim2_above(wd_lim2_above));
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic oe;
    host.bus_read(a, d, oe);
    chk_bit(oe, 1'b1);
    chk16(d, exp);
  endtask
  task automatic write_en(input logic [15:0] v);
    logic [15:0] d;
    logic oe;
    host.bus_write(ail_pkg::OFS_INT_ENABLE, v);
    host.bus_read(ail_pkg::OFS_INT_FLAGS, d, oe);
  endtask
  task automatic pulse(input int which);
    @(posedge sys_clk);
    case (which)
      0: azero_done <= 1'b1;
      1: fullcal_done <= 1'b1;
      default: cfg_reset_pulse <= 1'b1;
    endcase
    @(posedge sys_clk);
    azero_done <= 1'b0;
    fullcal_done <= 1'b0;
    cfg_reset_pulse <= 1'b0;
  endtask
  task automatic wait_clear(output logic seen);
    seen = 1'b0;
    // Sampling starts just after the calling edge, so a pulse launched at that edge is seen.
    repeat (4) begin
      #1 if (seq_clear === 1'b1) seen = 1'b1;
      @(posedge sys_clk);
    end
  endtask
  task automatic fetch(input logic [2:0] p, input logic pz);
    @(posedge sys_clk);
    fetch_valid <= 1'b1;
    fetch_ptr <= p;
    fetch_pause <= pz;
    @(posedge sys_clk);
    fetch_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wd(input logic [2:0] i, input logic [8:0] s, l1, input logic a1, input logic [8:0] l2,
                    input logic a2);
    @(posedge sys_clk);
    wd_start <= 1'b1;
    wd_instr <= i;
    wd_sample <= s;
    wd_lim1 <= l1;
    wd_lim1_above <= a1;
    wd_lim2 <= l2;
    wd_lim2_above <= a2;
    @(posedge sys_clk);
    wd_start <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic t_reset_state;
    logic [15:0] d;
    logic oe;
    rd(ail_pkg::OFS_INT_ENABLE, 16'h0000);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0000);
    rd(ail_pkg::OFS_LIMIT_HIT, 16'h0000);
    host.bus_read(4'h3, d, oe);
    chk_bit(oe, 1'b0);
  endtask
  task automatic t_events;
    pulse(0);
    pulse(1);
    repeat (3) @(posedge sys_clk);
    chk_bit(int_n, 1'b1);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0018);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0000);
  endtask
  task automatic t_mask;
    write_en(16'h0048);
    pulse(0);
    repeat (3) @(posedge sys_clk);
    chk_bit(int_n, 1'b0);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0008);
    chk_bit(int_n, 1'b1);
  endtask
  task automatic t_fetch;
    write_en(16'h0002);
    fetch(3'h0, 1'b1);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0020);
    fetch(3'h0, 1'b0);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0002);
  endtask
  task automatic t_fifo;
    logic seen;
    write_en(16'h1804);
    rd(ail_pkg::OFS_INT_ENABLE, 16'h1804);
    seq_running <= 1'b1;
    instruction_pointer <= 3'h5;
    fifo_count <= 6'h02;
    repeat (4) @(posedge sys_clk);
    chk_bit(int_n, 1'b1);
    fifo_count <= 6'h03;
    wait_clear(seen);
    chk_bit(seen, 1'b0);
    chk_bit(int_n, 1'b0);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h1d04);
    seq_running <= 1'b0;
    fifo_count <= 6'h00;
  endtask
  task automatic t_watchdog;
    wd(3'h6, 9'h064, 9'h032, 1'b1, 9'h0c8, 1'b1);
    wd(3'h3, 9'h1f6, 9'h000, 1'b1, 9'h000, 1'b0);
    rd(ail_pkg::OFS_LIMIT_HIT, 16'h0840);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0001);
    rd(ail_pkg::OFS_LIMIT_HIT, 16'h0000);
  endtask
  task automatic t_standby;
    logic seen;
    write_en(16'h0080);
    standby_bit <= 1'b1;
    repeat (5) @(posedge sys_clk);
    standby_bit <= 1'b0;
    wait_clear(seen);
    chk_bit(seen, 1'b1);
    repeat (12) @(posedge sys_clk);
    chk_bit(int_n, 1'b1);
    repeat (14) @(posedge sys_clk);
    chk_bit(int_n, 1'b0);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0080);
  endtask
  task automatic t_cfg_reset;
    logic seen;
    pulse(0);
    wd(3'h2, 9'h064, 9'h000, 1'b1, 9'h000, 1'b1);
    pulse(2);
    wait_clear(seen);
    chk_bit(seen, 1'b1);
    fetch(3'h0, 1'b0);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0000);
    rd(ail_pkg::OFS_LIMIT_HIT, 16'h0000);
    fetch(3'h0, 1'b0);
    rd(ail_pkg::OFS_INT_FLAGS, 16'h0002);
  endtask
  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (6) @(posedge sys_clk);
    t_reset_state;
    t_events;
    t_mask;
    t_fetch;
    t_fifo;
    t_watchdog;
    t_standby;
    t_cfg_reset;
    close_out;
  end
  // The whole sequence needs well under a thousand cycles of bus traffic.
  initial begin
    repeat (6000) @(posedge sys_clk);
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
